// file: dcic_pkg.sv
// Constants, register map and carrier types of the dual channel input capture block.
// Assumes one 20 MHz clock and an AXI4-Lite master that issues one access at a time.
package dcic_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    localparam int PRESC_W = 5;
    localparam logic [7:0] OFS_START = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_FUNC = 8'h08;
    localparam logic [7:0] OFS_CNTCTL0 = 8'h0C;
    localparam logic [7:0] OFS_IOAB0 = 8'h14;
    localparam logic [7:0] OFS_IOCD0 = 8'h1C;
    localparam logic [7:0] OFS_FILT0 = 8'h24;
    localparam logic [7:0] OFS_STAT0 = 8'h2C;
    localparam logic [7:0] OFS_CNT0 = 8'h34;
    localparam logic [7:0] OFS_CAP0 = 8'h40;
    localparam logic [7:0] OFS_CAP_END = 8'h5C;
    localparam logic [7:0] CH_STRIDE = 8'h04;
    // Field positions
    localparam int START_LSB = 0;
    localparam int STOPEN_LSB = 2;
    localparam int SYNC_BIT = 0;
    localparam int BUF_LSB = 4;
    localparam int EXTEN_BIT = 0;
    localparam int CC_SRC_LSB = 0;
    localparam int CC_EDGE_LSB = 3;
    localparam int CC_CLR_LSB = 5;
    localparam int IO_FLD_W = 4;
    localparam int IO_FUNC_BIT = 2;
    localparam int IO_TRIG_BIT = 3;
    localparam int FILT_SMP_LSB = 4;
    localparam int STAT_OVF_BIT = 4;
    // Reset values; trigger select of register A starts at 1 (pin)
    localparam logic [7:0] IOAB_RST = 8'h08;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // Count sources
    localparam logic [2:0] SRC_F1 = 3'h0;
    localparam logic [2:0] SRC_F2 = 3'h1;
    localparam logic [2:0] SRC_F4 = 3'h2;
    localparam logic [2:0] SRC_F8 = 3'h3;
    localparam logic [2:0] SRC_F32 = 3'h4;
    localparam logic [2:0] SRC_EXT = 3'h5;
    localparam logic [2:0] SRC_HSO = 3'h6;
    // Prescaler masks for /2 /4 /8 /32
    localparam logic [4:0] DIV2_M = 5'h01;
    localparam logic [4:0] DIV4_M = 5'h03;
    localparam logic [4:0] DIV8_M = 5'h07;
    localparam logic [4:0] DIV32_M = 5'h1F;
    // Clear select codes
    localparam logic [2:0] CLR_FREE = 3'h0;
    localparam logic [2:0] CLR_A = 3'h1;
    localparam logic [2:0] CLR_B = 3'h2;
    localparam logic [2:0] CLR_SYNC = 3'h3;
    localparam logic [2:0] CLR_C = 3'h5;
    localparam logic [2:0] CLR_D = 3'h6;
    // Edge codes, 1x means both edges
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    // Filter sampling clock codes
    localparam logic [1:0] SMP_F1 = 2'h0;
    localparam logic [1:0] SMP_F8 = 2'h1;
    localparam logic [1:0] SMP_F32 = 2'h2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] waddr;
        logic [ADDR_W-1:0] raddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } dcic_regacc_t;
endpackage

// file: dcic_pin_cond.sv
// Input conditioner: two-stage synchroniser, optional three-sample filter, edge pulses.
// Assumes sample_en is a one-cycle pulse from the parent's prescaler.
`timescale 1ns/1ns
module dcic_pin_cond
    import dcic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    input wire logic filt_en,
    input wire logic sample_en,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic [2:0] hist;
        logic level;
        logic rise;
        logic fall;
    } dcic_pin_state_t;

    dcic_pin_state_t s_r;
    dcic_pin_state_t s_nxt;
    logic lvl;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = pin_in;
        s_nxt.sync = s_r.meta;
        if (sample_en) begin
            s_nxt.hist = {s_r.hist[1:0], s_r.sync};
        end
        lvl = s_r.level;
        if (!filt_en) begin
            lvl = s_r.sync;
        end else if (&s_nxt.hist) begin
            lvl = 1'b1;
        end else if (~|s_nxt.hist) begin
            lvl = 1'b0;
        end
        s_nxt.level = lvl;
        s_nxt.rise = lvl & ~s_r.level;
        s_nxt.fall = ~lvl & s_r.level;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level;
    assign rise = s_r.rise;
    assign fall = s_r.fall;
endmodule // dcic_pin_cond

// file: dcic_axil.sv
// AXI4-Lite slave front end; turns bus transfers into single-cycle register strobes.
// Assumes the parent decodes the address and returns read data in the same cycle.
`timescale 1ns/1ns
module dcic_axil
    import dcic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output dcic_regacc_t acc,
    input wire logic [31:0] rd_data,
    input wire logic wr_hit,
    input wire logic rd_hit
);
    typedef struct packed {
        logic aw_full;
        logic [ADDR_W-1:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready;
        logic wready;
    } dcic_axil_state_t;

    dcic_axil_state_t s_r;
    dcic_axil_state_t s_nxt;

    always_comb begin
        acc.wr = s_r.aw_full & s_r.w_full & ~s_r.bvalid;
        acc.rd = s_axi_arvalid & s_r.arready;
        acc.waddr = s_r.awaddr;
        acc.raddr = s_axi_araddr;
        acc.wdata = s_r.wdata;
        acc.wstrb = s_r.wstrb;
    end

    always_comb begin
        s_nxt = s_r;
        if (s_axi_awvalid && !s_r.aw_full && !s_r.bvalid) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_full && !s_r.bvalid) begin
            s_nxt.w_full = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (acc.wr) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_hit ? AXI_OKAY : AXI_SLVERR;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (acc.rd) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_data;
            s_nxt.rresp = rd_hit ? AXI_OKAY : AXI_SLVERR;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        // Ready drops while a response is pending so only one write is in flight
        s_nxt.awready = ~s_nxt.aw_full & ~s_nxt.bvalid;
        s_nxt.wready = ~s_nxt.w_full & ~s_nxt.bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.arready <= 1'b1;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
endmodule // dcic_axil

// file: dcic_top.sv
// Two-channel 16-bit timer, input capture function, with AXI4-Lite register access.
// Assumes all pin inputs are synchronous to aclk; oscillator clocks arrive as sampled levels.
`timescale 1ns/1ns
module dcic_top
    import dcic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] capture_input_pin,
    input wire logic external_count_clock_pin,
    input wire logic high_speed_osc_clock,
    input wire logic low_speed_osc_div_clock,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] irq_req
);
    localparam int NSIG = 11;
    localparam int SIG_EXT = 8;
    localparam int SIG_HSO = 9;
    localparam int SIG_LSO = 10;

    typedef struct packed {
        logic [1:0] start;
        logic [1:0] stop_en;
        logic sync;
        logic [3:0] bufen;
        logic ext_en;
        logic [1:0][7:0] cntctl;
        logic [1:0][7:0] ioab;
        logic [1:0][7:0] iocd;
        logic [1:0][5:0] filt;
        logic [1:0][4:0] flags;
        logic [1:0][4:0] armed;
        logic [1:0][CNT_W-1:0] cnt;
        logic [7:0][CNT_W-1:0] cap;
        logic [PRESC_W-1:0] presc;
        logic [1:0] irq;
    } dcic_state_t;

    dcic_state_t s_r;
    dcic_state_t s_nxt;
    dcic_regacc_t acc;
    logic [31:0] rd_data;
    logic wr_hit;
    logic rd_hit;
    logic [NSIG-1:0] sig_in;
    logic [NSIG-1:0] sig_rise;
    logic [NSIG-1:0] sig_fall;
    logic [NSIG-1:0] sig_filt;
    logic [NSIG-1:0] sig_smp;
    logic [1:0] tick;
    logic [1:0] smp;
    logic [1:0][3:0] evt;
    logic [1:0][3:0] flag_set_cap;
    logic [1:0] clr_src;
    logic [1:0] clr_cnt;
    logic [1:0][4:0] flag_clr;
    logic [15:0] wd16;

    function automatic logic [7:0] chofs(input logic [7:0] base, input int ch);
        return (ch == 0) ? base : base + CH_STRIDE;
    endfunction

    function automatic logic addr_hit(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_CNT0 + CH_STRIDE
            || (a >= OFS_CAP0 && a <= OFS_CAP_END));
    endfunction

    function automatic logic [3:0] io_field(input dcic_state_t st, input int ch, input int j);
        return (j < 2) ? st.ioab[ch][j*IO_FLD_W +: IO_FLD_W]
                       : st.iocd[ch][(j-2)*IO_FLD_W +: IO_FLD_W];
    endfunction

    dcic_axil u_axil (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .acc(acc), .rd_data(rd_data), .wr_hit(wr_hit), .rd_hit(rd_hit)
    );

    assign sig_in = {low_speed_osc_div_clock, high_speed_osc_clock,
                     external_count_clock_pin, capture_input_pin};

    // Clock pins never use the filter and sample every cycle
    genvar g;
    generate
        for (g = 0; g < NSIG; g++) begin : g_sig
            if (g < 8) begin : g_cap
                assign sig_filt[g] = s_r.filt[g/4][g%4];
                assign sig_smp[g] = smp[g/4];
            end else begin : g_clk
                assign sig_filt[g] = 1'b0;
                assign sig_smp[g] = 1'b1;
            end
            dcic_pin_cond u_cond (
                .aclk(aclk), .aresetn(aresetn), .pin_in(sig_in[g]),
                .filt_en(sig_filt[g]), .sample_en(sig_smp[g]),
                .level(), .rise(sig_rise[g]), .fall(sig_fall[g])
            );
        end
    endgenerate

    // Count source and filter sampling rates
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            unique case (s_r.cntctl[ch][CC_SRC_LSB +: 3])
                SRC_F1: tick[ch] = 1'b1;
                SRC_F2: tick[ch] = (s_r.presc & DIV2_M) == DIV2_M;
                SRC_F4: tick[ch] = (s_r.presc & DIV4_M) == DIV4_M;
                SRC_F8: tick[ch] = (s_r.presc & DIV8_M) == DIV8_M;
                SRC_F32: tick[ch] = s_r.presc == DIV32_M;
                SRC_EXT: begin
                    // Edge choice is ignored unless the external input is enabled
                    if (!s_r.ext_en) begin
                        tick[ch] = 1'b0;
                    end else if (s_r.cntctl[ch][CC_EDGE_LSB +: 2] == EDGE_RISE) begin
                        tick[ch] = sig_rise[SIG_EXT];
                    end else if (s_r.cntctl[ch][CC_EDGE_LSB +: 2] == EDGE_FALL) begin
                        tick[ch] = sig_fall[SIG_EXT];
                    end else begin
                        tick[ch] = sig_rise[SIG_EXT] | sig_fall[SIG_EXT];
                    end
                end
                SRC_HSO: tick[ch] = sig_rise[SIG_HSO];
                default: tick[ch] = 1'b0;
            endcase
            unique case (s_r.filt[ch][FILT_SMP_LSB +: 2])
                SMP_F1: smp[ch] = 1'b1;
                SMP_F8: smp[ch] = (s_r.presc & DIV8_M) == DIV8_M;
                SMP_F32: smp[ch] = s_r.presc == DIV32_M;
                default: smp[ch] = tick[ch];
            endcase
        end
    end

    // Capture events per pin
    always_comb begin
        logic [3:0] f;
        logic pin_evt;
        logic [2:0] csel;
        f = '0;
        pin_evt = 1'b0;
        csel = '0;
        for (int ch = 0; ch < 2; ch++) begin
            for (int j = 0; j < 4; j++) begin
                f = io_field(s_r, ch, j);
                if (f[1:0] == EDGE_RISE) begin
                    pin_evt = sig_rise[ch*4+j];
                end else if (f[1:0] == EDGE_FALL) begin
                    pin_evt = sig_fall[ch*4+j];
                end else begin
                    pin_evt = sig_rise[ch*4+j] | sig_fall[ch*4+j];
                end
                // Only channel 0 honours the trigger select of register A
                if (ch == 0 && j == 0 && f[IO_FUNC_BIT] && !f[IO_TRIG_BIT]) begin
                    pin_evt = sig_rise[SIG_LSO];
                end
                evt[ch][j] = f[IO_FUNC_BIT] & pin_evt;
            end
            flag_set_cap[ch] = evt[ch];
            csel = s_r.cntctl[ch][CC_CLR_LSB +: 3];
            clr_src[ch] = (csel == CLR_A && evt[ch][0]) || (csel == CLR_B && evt[ch][1])
                || (csel == CLR_C && evt[ch][2]) || (csel == CLR_D && evt[ch][3]);
        end
        for (int ch = 0; ch < 2; ch++) begin
            clr_cnt[ch] = clr_src[ch] || (s_r.sync
                && s_r.cntctl[ch][CC_CLR_LSB +: 3] == CLR_SYNC && clr_src[1-ch]);
        end
    end

    // Read mux
    always_comb begin
        rd_data = '0;
        rd_hit = addr_hit(acc.raddr);
        wr_hit = addr_hit(acc.waddr);
        if (acc.raddr == OFS_START) begin
            rd_data[3:0] = {s_r.stop_en, s_r.start};
        end else if (acc.raddr == OFS_MODE) begin
            rd_data[7:0] = {s_r.bufen, 3'h0, s_r.sync};
        end else if (acc.raddr == OFS_FUNC) begin
            rd_data[0] = s_r.ext_en;
        end else if (acc.raddr >= OFS_CAP0 && acc.raddr <= OFS_CAP_END) begin
            rd_data[15:0] = s_r.cap[acc.raddr[4:2]];
        end
        for (int ch = 0; ch < 2; ch++) begin
            if (acc.raddr == chofs(OFS_CNTCTL0, ch)) rd_data[7:0] = s_r.cntctl[ch];
            if (acc.raddr == chofs(OFS_IOAB0, ch)) rd_data[7:0] = s_r.ioab[ch];
            if (acc.raddr == chofs(OFS_IOCD0, ch)) rd_data[7:0] = s_r.iocd[ch];
            if (acc.raddr == chofs(OFS_FILT0, ch)) rd_data[5:0] = s_r.filt[ch];
            if (acc.raddr == chofs(OFS_STAT0, ch)) rd_data[4:0] = s_r.flags[ch];
            if (acc.raddr == chofs(OFS_CNT0, ch)) rd_data[15:0] = s_r.cnt[ch];
        end
    end

    always_comb begin
        s_nxt = s_r;
        flag_clr = '0;
        wd16 = s_r.cnt[0];
        s_nxt.presc = s_r.presc + 1'b1;
        if (acc.wr && acc.wstrb[0]) begin
            if (acc.waddr == OFS_START) begin
                s_nxt.stop_en = acc.wdata[STOPEN_LSB +: 2];
                for (int ch = 0; ch < 2; ch++) begin
                    if (acc.wdata[START_LSB+ch]) begin
                        s_nxt.start[ch] = 1'b1;
                    end else if (acc.wdata[STOPEN_LSB+ch]) begin
                        s_nxt.start[ch] = 1'b0;
                    end
                end
            end
            if (acc.waddr == OFS_MODE) begin
                s_nxt.sync = acc.wdata[SYNC_BIT];
                s_nxt.bufen = acc.wdata[BUF_LSB +: 4];
            end
            if (acc.waddr == OFS_FUNC) s_nxt.ext_en = acc.wdata[EXTEN_BIT];
            for (int ch = 0; ch < 2; ch++) begin
                if (acc.waddr == chofs(OFS_CNTCTL0, ch)) s_nxt.cntctl[ch] = acc.wdata[7:0];
                if (acc.waddr == chofs(OFS_IOAB0, ch)) s_nxt.ioab[ch] = acc.wdata[7:0];
                if (acc.waddr == chofs(OFS_IOCD0, ch)) s_nxt.iocd[ch] = acc.wdata[7:0];
                if (acc.waddr == chofs(OFS_FILT0, ch)) s_nxt.filt[ch] = acc.wdata[5:0];
                if (acc.waddr == chofs(OFS_STAT0, ch)) begin
                    flag_clr[ch] = s_r.armed[ch] & ~acc.wdata[4:0];
                    s_nxt.armed[ch] = '0;
                end
            end
        end
        if (acc.rd) begin
            for (int ch = 0; ch < 2; ch++) begin
                if (acc.raddr == chofs(OFS_STAT0, ch)) begin
                    s_nxt.armed[ch] = s_r.flags[ch];
                end
            end
        end
        for (int ch = 0; ch < 2; ch++) begin
            // Buffer moves first so the old capture value is kept
            if (evt[ch][0]) begin
                if (s_r.bufen[ch*2]) s_nxt.cap[ch*4+2] = s_r.cap[ch*4];
                s_nxt.cap[ch*4] = s_r.cnt[ch];
            end
            if (evt[ch][1]) begin
                if (s_r.bufen[ch*2+1]) s_nxt.cap[ch*4+3] = s_r.cap[ch*4+1];
                s_nxt.cap[ch*4+1] = s_r.cnt[ch];
            end
            if (evt[ch][2] && !s_r.bufen[ch*2]) s_nxt.cap[ch*4+2] = s_r.cnt[ch];
            if (evt[ch][3] && !s_r.bufen[ch*2+1]) s_nxt.cap[ch*4+3] = s_r.cnt[ch];
        end
        for (int ch = 0; ch < 2; ch++) begin
            logic ovf;
            ovf = 1'b0;
            if (acc.wr && acc.wstrb[0] && (acc.waddr == chofs(OFS_CNT0, ch)
                || (s_r.sync && acc.waddr == chofs(OFS_CNT0, 1-ch)))) begin
                wd16 = {acc.wstrb[1] ? acc.wdata[15:8] : s_r.cnt[ch][15:8], acc.wdata[7:0]};
                s_nxt.cnt[ch] = wd16;
            end else if (clr_cnt[ch]) begin
                s_nxt.cnt[ch] = CNT_ZERO;
            end else if (s_r.start[ch] && tick[ch]) begin
                ovf = s_r.cnt[ch] == CNT_MAX;
                s_nxt.cnt[ch] = s_r.cnt[ch] + 1'b1;
            end
            // A new event wins over a clear in the same cycle
            s_nxt.flags[ch] = (s_r.flags[ch] & ~flag_clr[ch])
                | {ovf, flag_set_cap[ch]};
            s_nxt.irq[ch] = ovf | (|flag_set_cap[ch]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.ioab <= {IOAB_RST, IOAB_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign irq_req = s_r.irq;
endmodule // dcic_top

// file: dcic_chk.sv
// Checker for the register bus handshakes of the capture block.
// Assumes it is bound into dcic_top and sees only its ports.
`timescale 1ns/1ns
module dcic_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_r_lat: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer repeated");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_ar_gap: assert property (s_ar_take |=> !s_axi_arready)
        else $error("second read taken");
endmodule // dcic_chk
bind dcic_top dcic_chk u_dcic_chk (.*);

// file: dcic_pulse_src.sv
// Pulse source model standing at the eight capture pins.
// Assumes the bench calls drive from one process at a time.
`timescale 1ns/1ns
module dcic_pulse_src (
    input wire logic aclk,
    output logic [7:0] pin
);
    initial pin = 8'h00;
    // Holds each level four clocks, above the three-clock minimum pulse width
    task automatic drive(input int idx, input logic v);
        @(posedge aclk);
        pin[idx] <= v;
        repeat (4) @(posedge aclk);
    endtask
endmodule // dcic_pulse_src

// file: dcic_tb.sv
// Testbench of the capture block: register sequences over AXI4-Lite.
// Assumes the pulse source model drives the capture pins.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module dcic_tb;
    import dcic_pkg::*;
    logic aclk, aresetn, external_count_clock_pin, high_speed_osc_clock, low_speed_osc_div_clock;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_req;
    logic [7:0] s_axi_awaddr, s_axi_araddr, capture_input_pin;
    logic [31:0] s_axi_wdata, s_axi_rdata, d0, d1;
    logic [3:0] s_axi_wstrb;
    int tests_run, miscompares;
    int irq0, irq1;
    // Counts request pulses per channel, one per cycle with any capture or overflow
    always @(posedge aclk) begin
        if (irq_req[0]) irq0++;
        if (irq_req[1]) irq1++;
    end
    dcic_top u_dcic_top (.*);
    dcic_pulse_src u_dcic_pulse_src (.aclk(aclk), .pin(capture_input_pin));
    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] x = AXI_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, x)
    endtask
    // Keeps the last two read words in d0 and d1 for comparisons between reads
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit chk = 1'h1,
        input logic [1:0] x = AXI_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        d0 = d1;
        d1 = s_axi_rdata;
        if (chk) `CHK({s_axi_rresp, d1}, {x, e})
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        finish_test;
    end
    initial begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {external_count_clock_pin, high_speed_osc_clock, low_speed_osc_div_clock} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFS_IOAB0 + CH_STRIDE, 32'h08);
        rd(8'h60, 32'h0, 1'h1, AXI_SLVERR);
        wr(8'h60, 32'h0, AXI_SLVERR);
        wr(OFS_START, 32'h3);
        wr(OFS_START, 32'h0);
        rd(OFS_CNT0, 32'h0, 1'h0);
        rd(OFS_CNT0, 32'h0, 1'h0);
        `CHK(d1 != d0, 1'h1)
        wr(OFS_START, 32'hC);
        rd(OFS_CNT0, 32'h0, 1'h0);
        rd(OFS_CNT0, d1);
        wr(OFS_CNT0, 32'h1234);
        rd(OFS_CNT0 + CH_STRIDE, d1);
        wr(OFS_MODE, 32'h31);
        wr(OFS_IOCD0, 32'h04);
        wr(OFS_IOAB0, 32'h0D);
        wr(OFS_CNT0, 32'h5678);
        rd(OFS_CNT0 + CH_STRIDE, 32'h5678);
        u_dcic_pulse_src.drive(0, 1'h1);
        u_dcic_pulse_src.drive(0, 1'h0);
        rd(OFS_CAP0, 32'h5678);
        wr(OFS_STAT0, 32'h0);
        rd(OFS_STAT0, 32'h1);
        wr(OFS_STAT0, 32'h0);
        rd(OFS_STAT0, 32'h0);
        wr(OFS_IOAB0, 32'h0C);
        wr(OFS_CNT0, 32'h0111);
        u_dcic_pulse_src.drive(0, 1'h1);
        rd(OFS_CAP0, 32'h0111);
        rd(OFS_CAP0 + 8'h08, 32'h5678);
        wr(OFS_CNT0, 32'h0222);
        u_dcic_pulse_src.drive(0, 1'h0);
        rd(OFS_CAP0, 32'h0111);
        wr(OFS_IOAB0, 32'h0E);
        u_dcic_pulse_src.drive(0, 1'h1);
        wr(OFS_CNT0, 32'h0555);
        u_dcic_pulse_src.drive(0, 1'h0);
        rd(OFS_CAP0, 32'h0555);
        rd(OFS_CAP0 + 8'h08, 32'h0222);
        wr(OFS_CNTCTL0, 32'h20);
        wr(OFS_CNTCTL0 + CH_STRIDE, 32'h60);
        wr(OFS_IOAB0, 32'h04);
        wr(OFS_CNT0, 32'h0333);
        low_speed_osc_div_clock <= 1'h1;
        repeat (8) @(posedge aclk);
        rd(OFS_CAP0, 32'h0333);
        rd(OFS_CNT0, 32'h0);
        rd(OFS_CNT0 + CH_STRIDE, 32'h0);
        wr(OFS_CNT0, 32'hFFF0);
        wr(OFS_START, 32'h1);
        repeat (20) @(posedge aclk);
        rd(OFS_STAT0, 32'h11);
        `CHK(irq0, 6)
        `CHK(irq1, 0)
        finish_test;
    end
endmodule // dcic_tb
